// ==== hw/bws_cfg_if.sv ====
// Interface between the register block and the wait selection logic.
// Carries software settings one way and timer status the other.
`timescale 1ns/1ns
`default_nettype none

interface bws_cfg_if;
    logic [7:0] read_wait_sample;
    logic dram_write_long_pitch;
    logic [7:0] dma_read_wait_sample;
    logic [7:0] dma_write_wait_sample;
    logic [1:0] area02_long_wait;
    logic [1:0] area6_long_wait;
    logic busy;
    logic [7:0] last_waits;

    // Register block drives settings and reads status
    modport regs (
        output read_wait_sample, dram_write_long_pitch, dma_read_wait_sample,
        output dma_write_wait_sample, area02_long_wait, area6_long_wait,
        input busy, last_waits
    );
    // Core logic reads settings and drives status
    modport core (
        input read_wait_sample, dram_write_long_pitch, dma_read_wait_sample,
        input dma_write_wait_sample, area02_long_wait, area6_long_wait,
        output busy, last_waits
    );
endinterface

`default_nettype wire

// ==== hw/bws_pkg.sv ====
// Package for the bus wait-state controller: register map, field layout,
// reset values, cycle kinds, timer states and wait figures.
// Assumes a 16-bit register port addressed by 27-bit byte addresses.
package bws_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 27;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] CPU_WAIT_CONTROL_ADDR = 27'h5ffffa2;
    localparam logic [ADDR_W-1:0] DMA_WAIT_CONTROL_ADDR = 27'h5ffffa4;
    localparam logic [ADDR_W-1:0] LONG_WAIT_CONTROL_ADDR = 27'h5ffffa6;
    localparam logic [ADDR_W-1:0] WAIT_STATUS_ADDR = 27'h5ffffae;

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int READ_WAIT_LSB = 8;
    localparam int LONG_PITCH_BIT = 1;
    localparam int DMA_READ_LSB = 8;
    localparam int DMA_WRITE_LSB = 0;
    localparam int AREA02_LW_LSB = 13;
    localparam int AREA6_LW_LSB = 11;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_LAST_LSB = 8;
    localparam logic [15:0] CPU_WAIT_RESET = 16'hffff;
    localparam logic [15:0] CPU_WAIT_WMASK = 16'hff02;
    localparam logic [15:0] DMA_WAIT_RESET = 16'hffff;
    localparam logic [15:0] LONG_WAIT_RESET = 16'h7800;
    localparam logic [15:0] LONG_WAIT_WMASK = 16'h7800;
    localparam logic [1:0] LONG_WAIT_CODE_RESET = 2'h3;

    // ----------------------------------------------------------------
    // Areas and wait figures (counts of inserted wait cycles)
    // ----------------------------------------------------------------
    localparam logic [2:0] AREA_0 = 3'h0;
    localparam logic [2:0] AREA_1 = 3'h1;
    localparam logic [2:0] AREA_2 = 3'h2;
    localparam logic [2:0] AREA_6 = 3'h6;
    localparam logic [2:0] WAIT_NONE = 3'h0;
    localparam logic [2:0] WAIT_BASE_SAMPLED = 3'h2;
    localparam logic [2:0] WAIT_MUX_IO = 3'h4;
    localparam logic [7:0] LAST_WAITS_MAX = 8'hff;

    // Bus cycle kinds presented with a cycle start
    typedef enum logic [2:0] {
        BWS_CPU_READ = 3'h0,
        BWS_CPU_WRITE = 3'h1,
        BWS_DMA_READ = 3'h2,
        BWS_DMA_WRITE = 3'h3,
        BWS_REFRESH = 3'h4
    } bws_kind_t;

    // Wait timer states, Gray along idle, count, extend
    typedef enum logic [1:0] {
        BWS_IDLE = 2'b00,
        BWS_COUNT = 2'b01,
        BWS_EXTEND = 2'b11
    } bws_state_t;

    // Two-bit long wait code 00..11 to 1..4 wait cycles
    function automatic logic [2:0] long_wait_cycles(input logic [1:0] code);
        return {1'b0, code} + 3'h1;
    endfunction

endpackage

// ==== hw/bws_reg_file.sv ====
// Register block: wait control registers on a plain strobe port.
// Assumes one strobe at a time; read data stand in the next cycle only.
`timescale 1ns/1ns
`default_nettype none

module bws_reg_file (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Register port
    input wire logic [bws_pkg::ADDR_W-1:0] i_addr,
    input wire logic [bws_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [bws_pkg::DATA_W-1:0] o_rdata,
    // Settings and status
    bws_cfg_if.regs cfg
);
    logic [15:0] cpu_wait_control;
    logic [15:0] dma_wait_control;
    logic [15:0] long_wait_control;
    logic [15:0] wait_status;
    logic [15:0] next_rdata;

    // Writes; only writable bits change, the rest keep their reset value
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cpu_wait_control <= bws_pkg::CPU_WAIT_RESET;
            dma_wait_control <= bws_pkg::DMA_WAIT_RESET;
            long_wait_control <= bws_pkg::LONG_WAIT_RESET;
        end else if (i_wr) begin
            if (i_addr == bws_pkg::CPU_WAIT_CONTROL_ADDR) begin
                // Long-pitch bit is stored as written; software keeps it set
                // unless area 1 is DRAM
                cpu_wait_control <= (i_wdata & bws_pkg::CPU_WAIT_WMASK)
                                    | (bws_pkg::CPU_WAIT_RESET & ~bws_pkg::CPU_WAIT_WMASK);
            end
            if (i_addr == bws_pkg::DMA_WAIT_CONTROL_ADDR) begin
                dma_wait_control <= i_wdata;
            end
            if (i_addr == bws_pkg::LONG_WAIT_CONTROL_ADDR) begin
                long_wait_control <= i_wdata & bws_pkg::LONG_WAIT_WMASK;
            end
        end
    end

    // Status word shows the timer's own state
    always_comb begin
        wait_status = '0;
        wait_status[bws_pkg::STATUS_BUSY_BIT] = cfg.busy;
        wait_status[bws_pkg::STATUS_LAST_LSB +: 8] = cfg.last_waits;
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        unique case (i_addr)
            bws_pkg::CPU_WAIT_CONTROL_ADDR: next_rdata = cpu_wait_control;
            bws_pkg::DMA_WAIT_CONTROL_ADDR: next_rdata = dma_wait_control;
            bws_pkg::LONG_WAIT_CONTROL_ADDR: next_rdata = long_wait_control;
            bws_pkg::WAIT_STATUS_ADDR: next_rdata = wait_status;
            default: next_rdata = '0;
        endcase
    end

    // Read data valid in the cycle after the strobe only
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? next_rdata : '0;
        end
    end

    // Settings out to the selection logic
    assign cfg.read_wait_sample = cpu_wait_control[bws_pkg::READ_WAIT_LSB +: 8];
    assign cfg.dram_write_long_pitch = cpu_wait_control[bws_pkg::LONG_PITCH_BIT];
    assign cfg.dma_read_wait_sample = dma_wait_control[bws_pkg::DMA_READ_LSB +: 8];
    assign cfg.dma_write_wait_sample = dma_wait_control[bws_pkg::DMA_WRITE_LSB +: 8];
    assign cfg.area02_long_wait = long_wait_control[bws_pkg::AREA02_LW_LSB +: 2];
    assign cfg.area6_long_wait = long_wait_control[bws_pkg::AREA6_LW_LSB +: 2];
endmodule // bws_reg_file

`default_nettype wire

// ==== hw/bws_wait_ctrl.sv ====
// Top of the bus wait-state controller: per bus cycle, picks the number
// of wait cycles and whether WAIT is sampled, then times the waits.
// Assumes the bus sequencer presents area, kind and a start pulse, and
// that WAIT, DRAM select and multiplex I/O enable are synchronous levels.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Sampled areas 1,3-5,7: two waits plus WAIT
// - Sampled areas 0,2,6: long wait plus WAIT
// - Bit clear: WAIT ignored, fixed or long wait
// - Multiplex I/O: four waits plus WAIT always
// - DRAM write short pitch: no wait, no WAIT
// - Long pitch: two waits plus WAIT on writes
// - Refresh ignores WAIT, uses refresh long wait
// - Long wait codes give 1-4 cycles, reset 4
module bws_wait_ctrl (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Register port
    input wire logic [bws_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [bws_pkg::DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [bws_pkg::DATA_W-1:0] o_reg_rdata,
    // Space configuration from the bus control logic
    input wire logic i_area1_dram_select,
    input wire logic i_area6_mux_io,
    input wire logic [1:0] i_refresh_long_wait,
    // Bus cycle request
    input wire logic i_cyc_start,
    input wire logic [2:0] i_cyc_area,
    input wire logic [2:0] i_cyc_kind,
    // External WAIT pin, low when asserted
    input wire logic i_wait_n,
    // Cycle timing
    output logic o_wait_insert,
    output logic o_cyc_done,
    output logic o_busy
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    bws_cfg_if cfg ();

    bws_reg_file u_regs (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_addr(i_reg_addr),
        .i_wdata(i_reg_wdata),
        .i_wr(i_reg_wr),
        .i_rd(i_reg_rd),
        .o_rdata(o_reg_rdata),
        .cfg(cfg.regs)
    );

    // ----------------------------------------------------------------
    // Wait selection
    // ----------------------------------------------------------------
    bws_pkg::bws_kind_t kind;
    logic [2:0] base_waits;
    logic sample_wait;
    logic sample_bit;
    logic long_area;
    logic [2:0] long_waits;
    logic long_pitch;

    assign kind = bws_pkg::bws_kind_t'(i_cyc_kind);

    // Per-area sampling bit for the cycle kind
    always_comb begin
        sample_bit = 1'b1;
        unique case (kind)
            bws_pkg::BWS_CPU_READ: sample_bit = cfg.read_wait_sample[i_cyc_area];
            bws_pkg::BWS_CPU_WRITE: sample_bit = (i_cyc_area == bws_pkg::AREA_1)
                                                 ? cfg.dram_write_long_pitch : 1'b1;
            bws_pkg::BWS_DMA_READ: sample_bit = cfg.dma_read_wait_sample[i_cyc_area];
            bws_pkg::BWS_DMA_WRITE: sample_bit = cfg.dma_write_wait_sample[i_cyc_area];
            bws_pkg::BWS_REFRESH: sample_bit = 1'b0;
            default: sample_bit = 1'b1;
        endcase
    end

    // Areas 0, 2 and 6 carry a programmable long wait
    assign long_area = (i_cyc_area == bws_pkg::AREA_0) || (i_cyc_area == bws_pkg::AREA_2)
                       || (i_cyc_area == bws_pkg::AREA_6);
    assign long_waits = (i_cyc_area == bws_pkg::AREA_6)
                        ? bws_pkg::long_wait_cycles(cfg.area6_long_wait)
                        : bws_pkg::long_wait_cycles(cfg.area02_long_wait);
    // Column pitch: CPU writes use the long-pitch bit, all other cycles use the sampling bit
    assign long_pitch = (kind == bws_pkg::BWS_CPU_WRITE) ? cfg.dram_write_long_pitch : sample_bit;

    // Base wait count and WAIT sampling for the cycle
    always_comb begin
        base_waits = bws_pkg::WAIT_NONE;
        sample_wait = 1'b0;
        if (kind == bws_pkg::BWS_REFRESH) begin
            base_waits = bws_pkg::long_wait_cycles(i_refresh_long_wait);
            sample_wait = 1'b0;
        end else if (i_cyc_area == bws_pkg::AREA_6 && i_area6_mux_io) begin
            base_waits = bws_pkg::WAIT_MUX_IO;
            sample_wait = 1'b1;
        end else if (i_cyc_area == bws_pkg::AREA_1 && i_area1_dram_select) begin
            if (long_pitch) begin
                base_waits = bws_pkg::WAIT_BASE_SAMPLED;
                sample_wait = 1'b1;
            end else begin
                base_waits = bws_pkg::WAIT_NONE;
                sample_wait = 1'b0;
            end
        end else if (long_area) begin
            base_waits = long_waits;
            sample_wait = sample_bit;
        end else if (sample_bit) begin
            base_waits = bws_pkg::WAIT_BASE_SAMPLED;
            sample_wait = 1'b1;
        end else begin
            base_waits = bws_pkg::WAIT_NONE;
            sample_wait = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Wait timing
    // ----------------------------------------------------------------
    logic timer_busy;
    logic [7:0] timer_last;

    bws_wait_timer #(
        .CNT_W(3)
    ) u_timer (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_start(i_cyc_start),
        .i_base(base_waits),
        .i_sample(sample_wait),
        .i_wait_asserted(!i_wait_n),
        .o_insert(o_wait_insert),
        .o_done(o_cyc_done),
        .o_busy(timer_busy),
        .o_last_waits(timer_last)
    );

    // Status back to the register block and out
    assign cfg.busy = timer_busy;
    assign cfg.last_waits = timer_last;
    assign o_busy = timer_busy;
endmodule // bws_wait_ctrl

`default_nettype wire

// ==== hw/bws_wait_timer.sv ====
// Wait timer: inserts a base number of wait cycles, then extends while
// the external WAIT input is asserted if sampling was chosen.
// Assumes the WAIT level is already synchronous to i_clk_sys.
`timescale 1ns/1ns
`default_nettype none

module bws_wait_timer #(
    parameter int CNT_W = 3
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Cycle request
    input wire logic i_start,
    input wire logic [CNT_W-1:0] i_base,
    input wire logic i_sample,
    input wire logic i_wait_asserted,
    // Status
    output logic o_insert,
    output logic o_done,
    output logic o_busy,
    output logic [7:0] o_last_waits
);
    bws_pkg::bws_state_t state;
    logic [CNT_W-1:0] cnt;
    logic sample_q;
    logic [7:0] run_waits;
    logic finish;

    // Last wait cycle ends without extension, or extension ends
    assign finish = (state == bws_pkg::BWS_COUNT && cnt == CNT_W'(1) && !(sample_q && i_wait_asserted))
                    || (state == bws_pkg::BWS_EXTEND && !i_wait_asserted);
    assign o_busy = (state != bws_pkg::BWS_IDLE);

    // State, down counter and sampling choice
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state <= bws_pkg::BWS_IDLE;
            cnt <= '0;
            sample_q <= 1'b0;
        end else begin
            unique case (state)
                bws_pkg::BWS_IDLE: begin
                    if (i_start && i_base != '0) begin
                        state <= bws_pkg::BWS_COUNT;
                        cnt <= i_base;
                        sample_q <= i_sample;
                    end
                end
                bws_pkg::BWS_COUNT: begin
                    if (cnt != CNT_W'(1)) begin
                        cnt <= cnt - CNT_W'(1);
                    end else if (sample_q && i_wait_asserted) begin
                        state <= bws_pkg::BWS_EXTEND;
                    end else begin
                        state <= bws_pkg::BWS_IDLE;
                    end
                end
                bws_pkg::BWS_EXTEND: begin
                    if (!i_wait_asserted) begin
                        state <= bws_pkg::BWS_IDLE;
                    end
                end
                default: begin
                    state <= bws_pkg::BWS_IDLE;
                end
            endcase
        end
    end

    // Wait insertion level and end-of-cycle pulse
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_insert <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= (state == bws_pkg::BWS_IDLE && i_start && i_base == '0) || finish;
            if (state == bws_pkg::BWS_IDLE) begin
                o_insert <= i_start && i_base != '0;
            end else if (finish) begin
                o_insert <= 1'b0;
            end
        end
    end

    // Count of waits inserted, saturating, published when a cycle ends
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            run_waits <= '0;
            o_last_waits <= '0;
        end else begin
            if (state == bws_pkg::BWS_IDLE) begin
                run_waits <= 8'h01;
                if (i_start && i_base == '0) begin
                    o_last_waits <= '0;
                end
            end else if (finish) begin
                o_last_waits <= run_waits;
            end else if (run_waits != bws_pkg::LAST_WAITS_MAX) begin
                run_waits <= run_waits + 8'h01;
            end
        end
    end
endmodule // bws_wait_timer

`default_nettype wire

// ==== test/bws_mem_model.sv ====
// External memory model on the far side of the wait-state controller.
// Assumes the controller's insert level; answers slowly by holding WAIT.
`timescale 1ns/1ns
`default_nettype none

module bws_mem_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Controller side
    input wire logic i_insert,
    input wire logic [3:0] i_hold,
    // WAIT pin, low when asserted
    output logic o_wait_n
);
    logic [3:0] cnt;

    // Counts wait cycles seen in the current insert run
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 4'h0;
        end else if (!i_insert) begin
            cnt <= 4'h0;
        end else if (cnt != 4'hf) begin
            cnt <= cnt + 4'h1;
        end
    end

    // Slow memory holds WAIT for the first i_hold insert cycles; pull-up idles high
    assign o_wait_n = !(i_insert && cnt < i_hold);
endmodule // bws_mem_model

`default_nettype wire

// ==== test/bws_wait_ctrl_asserts.sv ====
// Checker for the wait-state controller, watching only the top ports.
// Assumes bws_pkg is compiled first; bound to every bws_wait_ctrl.
`timescale 1ns/1ns
`default_nettype none

module bws_wait_ctrl_asserts (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Register port
    input wire logic [bws_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [bws_pkg::DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [bws_pkg::DATA_W-1:0] o_reg_rdata,
    // Space configuration and cycle request
    input wire logic i_area1_dram_select,
    input wire logic i_area6_mux_io,
    input wire logic [1:0] i_refresh_long_wait,
    input wire logic i_cyc_start,
    input wire logic [2:0] i_cyc_area,
    input wire logic [2:0] i_cyc_kind,
    input wire logic i_wait_n,
    // Cycle timing
    input wire logic o_wait_insert,
    input wire logic o_cyc_done,
    input wire logic o_busy
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    logic [15:0] cpu_w;
    logic take;
    logic fixed_area;
    logic rd_bit;

    // Shadow of the CPU wait register
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cpu_w <= 16'hffff;
        end else if (i_reg_wr && i_reg_addr == bws_pkg::CPU_WAIT_CONTROL_ADDR) begin
            cpu_w <= i_reg_wdata;
        end
    end

    // Accepted start, area class and its read sampling bit
    assign take = i_cyc_start && !o_busy;
    assign fixed_area = !(i_cyc_area inside {3'h0, 3'h2, 3'h6});
    assign rd_bit = cpu_w[8 + i_cyc_area];

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_base2;
        take && i_cyc_kind == 3'h0 && fixed_area && rd_bit |=> o_wait_insert [*2];
    endproperty
    a_base2: assert property (p_base2) else $error("sampled read lacks two waits");
    property p_fixed1;
        take && i_cyc_kind == 3'h0 && fixed_area && !rd_bit |=> o_cyc_done && !o_wait_insert;
    endproperty
    a_fixed1: assert property (p_fixed1) else $error("unsampled read not one cycle");
    property p_mux4;
        take && i_cyc_kind != 3'h4 && i_cyc_area == 3'h6 && i_area6_mux_io |=> o_wait_insert [*4];
    endproperty
    a_mux4: assert property (p_mux4) else $error("mux io lacks four waits");
    property p_short;
        take && i_cyc_kind == 3'h1 && i_cyc_area == 3'h1 && i_area1_dram_select && !cpu_w[1]
            |=> o_cyc_done && !o_wait_insert;
    endproperty
    a_short: assert property (p_short) else $error("short pitch write has waits");
    property p_long_pitch;
        take && i_cyc_kind == 3'h1 && i_cyc_area == 3'h1 && cpu_w[1] |=> o_wait_insert [*2];
    endproperty
    a_long_pitch: assert property (p_long_pitch) else $error("long pitch lacks two waits");
    property p_refresh1;
        take && i_cyc_kind == 3'h4 && i_refresh_long_wait == 2'h0
            |=> o_wait_insert ##1 (o_cyc_done && !o_wait_insert);
    endproperty
    a_refresh1: assert property (p_refresh1) else $error("refresh code 0 not one wait");
    property p_refresh4;
        take && i_cyc_kind == 3'h4 && i_refresh_long_wait == 2'h3 |=> o_wait_insert [*4] ##1 !o_wait_insert;
    endproperty
    a_refresh4: assert property (p_refresh4) else $error("refresh code 3 not four waits");
    property p_done;
        $fell(o_wait_insert) |-> o_cyc_done && !o_busy;
    endproperty
    a_done: assert property (p_done) else $error("no done after waits");
    property p_rd_idle;
        !$past(i_reg_rd) |-> o_reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_ro_bits;
        i_reg_rd && i_reg_addr == bws_pkg::CPU_WAIT_CONTROL_ADDR |=> o_reg_rdata[7:2] == 6'h3f && o_reg_rdata[0];
    endproperty
    a_ro_bits: assert property (p_ro_bits) else $error("read-only bits not one");

    // Main scenarios
    c_refresh: cover property (take && i_cyc_kind == 3'h4);
    c_mux: cover property (take && i_cyc_area == 3'h6 && i_area6_mux_io);
    c_extend: cover property (o_wait_insert && !i_wait_n);
endmodule // bws_wait_ctrl_asserts

bind bws_wait_ctrl bws_wait_ctrl_asserts i_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_area1_dram_select(i_area1_dram_select), .i_area6_mux_io(i_area6_mux_io),
    .i_refresh_long_wait(i_refresh_long_wait), .i_cyc_start(i_cyc_start), .i_cyc_area(i_cyc_area),
    .i_cyc_kind(i_cyc_kind), .i_wait_n(i_wait_n), .o_wait_insert(o_wait_insert),
    .o_cyc_done(o_cyc_done), .o_busy(o_busy));

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the wait-state controller.
// Assumes the memory model on WAIT and the bound checker.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, gt); end end

module tb;
    logic i_clk_sys, i_rst, wr, rd, dram, mux, start, ins, done, busy, wait_n;
    logic [26:0] addr;
    logic [15:0] wdata, rdata;
    logic [1:0] refr;
    logic [2:0] area, kind;
    logic [3:0] hold;
    int error_cnt = 0;
    int comparisons = 0;

    bws_wait_ctrl i_bws_wait_ctrl (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_area1_dram_select(dram), .i_area6_mux_io(mux), .i_refresh_long_wait(refr),
        .i_cyc_start(start), .i_cyc_area(area), .i_cyc_kind(kind), .i_wait_n(wait_n),
        .o_wait_insert(ins), .o_cyc_done(done), .o_busy(busy));
    bws_mem_model i_bws_mem_model (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_insert(ins),
        .i_hold(hold), .o_wait_n(wait_n));

    // 20 MHz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    // ----------------------------------------------------------------
    // Bus and cycle tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [26:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk_sys);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [26:0] a, input logic [15:0] ex);
        @(posedge i_clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk_sys);
        rd <= 1'b0;
        #5;
        `CHK("rdata", ex, rdata)
    endtask
    // One bus cycle; counts inserted waits up to done
    task automatic cyc(input logic [2:0] a, input logic [2:0] k, input logic [3:0] h, input logic [7:0] ex);
        logic [7:0] n;
        int i;
        n = 8'h0;
        @(posedge i_clk_sys);
        hold <= h;
        area <= a;
        kind <= k;
        start <= 1'b1;
        @(posedge i_clk_sys);
        start <= 1'b0;
        for (i = 0; i < 40; i++) begin
            #5;
            if (done === 1'b1) break;
            `CHK("busy", 1'b1, busy)
            if (ins === 1'b1) n++;
            @(posedge i_clk_sys);
        end
        if (i == 40) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", "done", 1'b1, 1'b0);
            end_of_test();
        end else begin
            `CHK("waits", ex, n)
        end
        // End on an edge so that later level changes land there
        @(posedge i_clk_sys);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        reg_rd(bws_pkg::CPU_WAIT_CONTROL_ADDR, 16'hffff);
        reg_rd(bws_pkg::DMA_WAIT_CONTROL_ADDR, 16'hffff);
        reg_rd(bws_pkg::LONG_WAIT_CONTROL_ADDR, 16'h7800);
        reg_rd(27'h5ffffa8, 16'h0000);
        reg_wr(bws_pkg::LONG_WAIT_CONTROL_ADDR, 16'hffff);
        reg_rd(bws_pkg::LONG_WAIT_CONTROL_ADDR, 16'h7800);
        reg_wr(bws_pkg::CPU_WAIT_CONTROL_ADDR, 16'h2002);
        reg_rd(bws_pkg::CPU_WAIT_CONTROL_ADDR, 16'h20ff);
        $display("Test registers done");
    endtask
    task automatic t_cpu_read();
        cyc(3'h3, 3'h0, 4'h2, 8'h0);
        cyc(3'h5, 3'h0, 4'h0, 8'h2);
        cyc(3'h5, 3'h0, 4'h2, 8'h3);
        reg_rd(bws_pkg::WAIT_STATUS_ADDR, 16'h0300);
        cyc(3'h7, 3'h0, 4'h3, 8'h0);
        $display("Test cpu read done");
    endtask
    task automatic t_long();
        logic [1:0] c;
        for (int j = 0; j < 4; j++) begin
            c = j[1:0];
            reg_wr(bws_pkg::LONG_WAIT_CONTROL_ADDR, {1'b0, c, c, 11'h0});
            cyc(3'h0, 3'h0, 4'h3, {6'h0, c} + 8'h1);
            cyc(3'h6, 3'h0, 4'h0, {6'h0, c} + 8'h1);
        end
        reg_wr(bws_pkg::CPU_WAIT_CONTROL_ADDR, 16'hffff);
        reg_wr(bws_pkg::LONG_WAIT_CONTROL_ADDR, 16'h0000);
        cyc(3'h2, 3'h0, 4'h4, 8'h5);
        $display("Test long waits done");
    endtask
    task automatic t_mux();
        mux <= 1'b1;
        reg_wr(bws_pkg::CPU_WAIT_CONTROL_ADDR, 16'h0002);
        cyc(3'h6, 3'h0, 4'h0, 8'h4);
        cyc(3'h6, 3'h0, 4'h5, 8'h6);
        mux <= 1'b0;
        $display("Test mux io done");
    endtask
    task automatic t_dram();
        dram <= 1'b1;
        reg_wr(bws_pkg::CPU_WAIT_CONTROL_ADDR, 16'hff00);
        cyc(3'h1, 3'h1, 4'h3, 8'h0);
        reg_wr(bws_pkg::CPU_WAIT_CONTROL_ADDR, 16'hffff);
        cyc(3'h1, 3'h1, 4'h3, 8'h4);
        dram <= 1'b0;
        cyc(3'h1, 3'h1, 4'h0, 8'h2);
        $display("Test dram pitch done");
    endtask
    task automatic t_refresh();
        for (int j = 0; j < 4; j++) begin
            refr <= j[1:0];
            cyc(3'h3, 3'h4, 4'h5, {6'h0, j[1:0]} + 8'h1);
        end
        $display("Test refresh done");
    endtask
    task automatic t_dma();
        reg_wr(bws_pkg::DMA_WAIT_CONTROL_ADDR, 16'h00ff);
        cyc(3'h3, 3'h2, 4'h2, 8'h0);
        cyc(3'h3, 3'h3, 4'h2, 8'h3);
        cyc(3'h0, 3'h2, 4'h3, 8'h1);
        $display("Test dma done");
    endtask

    // Main sequence
    initial begin
        i_rst = 1'b1;
        {wr, rd, dram, mux, start} = 5'h0;
        addr = 27'h0;
        wdata = 16'h0;
        refr = 2'h0;
        area = 3'h0;
        kind = 3'h0;
        hold = 4'h0;
        repeat (20) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_regs();
        t_cpu_read();
        t_long();
        t_mux();
        t_dram();
        t_refresh();
        t_dma();
        end_of_test();
    end
endmodule // tb

`default_nettype wire
